// *** hw/prp_pkg.sv ***
/*
 Shared constants and carriers for the redundancy trailer and duplicate control block.
 Assumes a single 25 MHz system clock and a plain register port.
*/
package prp_pkg;
    localparam logic [7:0]  PRP_OFS_CONFIG   = 8'h00;
    localparam logic [7:0]  PRP_OFS_GROUP    = 8'h04;
    localparam logic [7:0]  PRP_OFS_SUFFIX   = 8'h08;
    localparam logic [7:0]  PRP_OFS_LANID    = 8'h0C;
    localparam logic [7:0]  PRP_OFS_SEQ      = 8'h10;
    localparam logic [7:0]  PRP_OFS_STAT_DUP = 8'h14;
    localparam logic [7:0]  PRP_OFS_STAT_STR = 8'h18;
    localparam logic [7:0]  PRP_OFS_STAT_TRL = 8'h1C;
    localparam int          PRP_POS_ENA      = 0;
    localparam int          PRP_POS_DUPACC   = 1;
    localparam int          PRP_POS_STRIP    = 2;
    localparam int          PRP_POS_MODE_LO  = 3;
    localparam int          PRP_POS_MODE_HI  = 4;
    localparam int          PRP_POS_LANB_LO  = 16;
    localparam logic [31:0] PRP_RST_CONFIG   = 32'h0000_0000;
    localparam logic [3:0]  PRP_RST_GROUP    = 4'h3;
    localparam logic [3:0]  PRP_RST_LANB     = 4'h2;
    localparam logic [15:0] PRP_RST_SUFFIX   = 16'h88FB;
    localparam logic [3:0]  PRP_RST_LANA_ID  = 4'hA;
    localparam logic [3:0]  PRP_RST_LANB_ID  = 4'hB;

    typedef enum logic [1:0] {
        PRP_MODE_GROUP_ONLY = 2'b00,
        PRP_MODE_GROUP_ANY  = 2'b01,
        PRP_MODE_DISABLED   = 2'b10,
        PRP_MODE_FORCED     = 2'b11
    } prp_mode_t;

    // per-frame transmit request from forwarding logic
    typedef struct packed {
        logic [3:0]  dest_mask;
        logic        is_bpdu;
        logic [10:0] frame_size;
    } prp_tx_req_t;

    // per-port trailer decision and contents
    typedef struct packed {
        logic [3:0]  append_mask;
        logic [15:0] seq_num;
        logic [3:0]  lan_id_a;
        logic [3:0]  lan_id_b;
        logic [3:0]  lan_b_sel;
        logic [10:0] frame_size;
        logic [15:0] suffix;
    } prp_tx_dec_t;

    // per-frame receive descriptor
    typedef struct packed {
        logic [3:0] rx_port;
        logic       is_bpdu;
        logic       is_ptp;
        logic       has_trailer;
        logic [3:0] src_port_mask;
        logic [3:0] lan_id;
        logic       is_dup;
    } prp_rx_req_t;

    typedef struct packed {
        logic strip;
        logic discard;
        logic dup_check;
    } prp_rx_dec_t;
endpackage

// *** hw/prp_trailer_dup_control.sv ***
/*
 Redundancy trailer append/strip decisions and duplicate discard control.
 Assumes the forwarding logic presents one descriptor per frame, one cycle long,
 and the duplicate history lookup is done outside and reported as is_dup.
*/
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - two-bit transmit mode at bits 4:3
// - mode 00: trailer only exactly both grouped
// - mode 01: trailer when both grouped reached
// - mode 10: never append trailer
// - mode 11: trailer on every grouped port the frame is sent to
// - bridge protocol frames never get trailer
// - ports outside group never get trailer
// - strip bit 2 removes trailer on group
// - strip only for known pair, lan match
// - duplicate check unaffected by strip bit
// - bridge and time frames never stripped
// - accept bit 1 skips duplicate detection
// - accept bit clear discards duplicates
// - bridge and time frames skip dup check
// - without support accept bit reads one
// - clearing enable clears statistics counters
// - four-bit mask names the redundant pair
// - select mask picks lan b port
module prp_trailer_dup_control
    import prp_pkg::*;
#(
    parameter bit PRP_SUPPORTED = 1'b1,
    parameter int CNT_W         = 32
) (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        tx_valid_i,
    input  wire prp_tx_req_t tx_req_i,
    output logic             tx_dec_valid_o,
    output prp_tx_dec_t      tx_dec_o,
    input  wire logic        rx_valid_i,
    input  wire prp_rx_req_t rx_req_i,
    output logic             rx_dec_valid_o,
    output prp_rx_dec_t      rx_dec_o
);
    logic [31:0]      cfg_q,    cfg_d;
    logic [3:0]       group_q,  group_d;
    logic [3:0]       lanb_q,   lanb_d;
    logic [15:0]      suffix_q, suffix_d;
    logic [7:0]       lanid_q,  lanid_d;
    logic [15:0]      seq_q,    seq_d;
    logic [CNT_W-1:0] cnt_dup_q, cnt_dup_d;
    logic [CNT_W-1:0] cnt_str_q, cnt_str_d;
    logic [CNT_W-1:0] cnt_trl_q, cnt_trl_d;
    logic [31:0]      rdata_q,  rdata_d;
    logic             txv_q,    txv_d;
    prp_tx_dec_t      txd_q,    txd_d;
    logic             rxv_q,    rxv_d;
    prp_rx_dec_t      rxd_q,    rxd_d;

    prp_mode_t  mode;
    logic       ena;
    logic       dup_acc;
    logic       strip_en;
    logic [3:0] in_grp;
    logic       both;
    logic       only_grp;
    logic [3:0] app;
    logic       rx_on_grp;
    logic       special;
    logic       lan_ok;
    logic [3:0] exp_id;

    always_comb begin
        mode     = prp_mode_t'(cfg_q[PRP_POS_MODE_HI:PRP_POS_MODE_LO]);
        ena      = cfg_q[PRP_POS_ENA];
        dup_acc  = PRP_SUPPORTED ? cfg_q[PRP_POS_DUPACC] : 1'b1;
        strip_en = cfg_q[PRP_POS_STRIP];
        // group mask assumed to hold two bits; otherwise result undefined
        in_grp   = tx_req_i.dest_mask & group_q;
        both     = (in_grp == group_q);
        only_grp = ((tx_req_i.dest_mask & ~group_q) == 4'h0);
        app      = 4'h0;
        case (mode)
            PRP_MODE_GROUP_ONLY: app = (both && only_grp) ? group_q : 4'h0;
            PRP_MODE_GROUP_ANY:  app = both ? group_q : 4'h0;
            PRP_MODE_DISABLED:   app = 4'h0;
            PRP_MODE_FORCED:     app = in_grp;
            default:             app = 4'h0;
        endcase
        if (tx_req_i.is_bpdu || !ena) begin
            app = 4'h0;
        end
        app = app & group_q;

        rx_on_grp = |(rx_req_i.rx_port & group_q);
        special   = rx_req_i.is_bpdu || rx_req_i.is_ptp;
        exp_id    = |(rx_req_i.rx_port & lanb_q) ? lanid_q[7:4] : lanid_q[3:0];
        lan_ok    = (rx_req_i.lan_id == exp_id) &&
                    ((rx_req_i.src_port_mask & group_q) == group_q);
    end

    always_comb begin
        cfg_d     = cfg_q;
        group_d   = group_q;
        lanb_d    = lanb_q;
        suffix_d  = suffix_q;
        lanid_d   = lanid_q;
        seq_d     = seq_q;
        cnt_dup_d = cnt_dup_q;
        cnt_str_d = cnt_str_q;
        cnt_trl_d = cnt_trl_q;
        rdata_d   = 32'h0000_0000;

        txv_d = tx_valid_i;
        txd_d = txd_q;
        if (tx_valid_i) begin
            txd_d.append_mask = app;
            txd_d.seq_num     = seq_q;
            txd_d.lan_id_a    = lanid_q[3:0];
            txd_d.lan_id_b    = lanid_q[7:4];
            txd_d.lan_b_sel   = lanb_q & group_q;
            txd_d.frame_size  = tx_req_i.frame_size;
            txd_d.suffix      = suffix_q;
            if (|app) begin
                // one sequence number shared by both copies of a frame
                seq_d     = seq_q + 16'h0001;
                cnt_trl_d = cnt_trl_q + CNT_W'(1);
            end
        end

        rxv_d = rx_valid_i;
        rxd_d = rxd_q;
        if (rx_valid_i) begin
            rxd_d.strip     = ena && strip_en && rx_on_grp && !special &&
                              rx_req_i.has_trailer && lan_ok;
            // dup check ignores the strip bit entirely
            rxd_d.dup_check = ena && rx_on_grp && !dup_acc && !special;
            rxd_d.discard   = rxd_d.dup_check && rx_req_i.is_dup;
            if (rxd_d.discard) begin
                cnt_dup_d = cnt_dup_q + CNT_W'(1);
            end
            if (rxd_d.strip) begin
                cnt_str_d = cnt_str_q + CNT_W'(1);
            end
        end

        if (reg_wr_i) begin
            if (reg_addr_i == PRP_OFS_CONFIG) begin
                cfg_d = {27'h0, reg_wdata_i[4:0]};
                if (!PRP_SUPPORTED) begin
                    cfg_d[PRP_POS_DUPACC] = 1'b1;
                end
            end else if (reg_addr_i == PRP_OFS_GROUP) begin
                group_d = reg_wdata_i[3:0];
                lanb_d  = reg_wdata_i[PRP_POS_LANB_LO+3:PRP_POS_LANB_LO];
            end else if (reg_addr_i == PRP_OFS_SUFFIX) begin
                suffix_d = reg_wdata_i[15:0];
            end else if (reg_addr_i == PRP_OFS_LANID) begin
                lanid_d = reg_wdata_i[7:0];
            end
        end
        // counters held clear while disabled; this also wins over any event
        if (!cfg_d[PRP_POS_ENA]) begin
            cnt_dup_d = '0;
            cnt_str_d = '0;
            cnt_trl_d = '0;
        end

        if (reg_rd_i) begin
            if (reg_addr_i == PRP_OFS_CONFIG) begin
                rdata_d = {27'h0, cfg_q[4:2], dup_acc, cfg_q[0]};
            end else if (reg_addr_i == PRP_OFS_GROUP) begin
                rdata_d = {12'h0, lanb_q, 12'h0, group_q};
            end else if (reg_addr_i == PRP_OFS_SUFFIX) begin
                rdata_d = {16'h0, suffix_q};
            end else if (reg_addr_i == PRP_OFS_LANID) begin
                rdata_d = {24'h0, lanid_q};
            end else if (reg_addr_i == PRP_OFS_SEQ) begin
                rdata_d = {16'h0, seq_q};
            end else if (reg_addr_i == PRP_OFS_STAT_DUP) begin
                rdata_d = 32'(cnt_dup_q);
            end else if (reg_addr_i == PRP_OFS_STAT_STR) begin
                rdata_d = 32'(cnt_str_q);
            end else if (reg_addr_i == PRP_OFS_STAT_TRL) begin
                rdata_d = 32'(cnt_trl_q);
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_q     <= PRP_SUPPORTED ? PRP_RST_CONFIG : (PRP_RST_CONFIG | 32'h0000_0002);
            group_q   <= PRP_RST_GROUP;
            lanb_q    <= PRP_RST_LANB;
            suffix_q  <= PRP_RST_SUFFIX;
            lanid_q   <= {PRP_RST_LANB_ID, PRP_RST_LANA_ID};
            seq_q     <= 16'h0000;
            cnt_dup_q <= '0;
            cnt_str_q <= '0;
            cnt_trl_q <= '0;
            rdata_q   <= 32'h0000_0000;
            txv_q     <= 1'b0;
            txd_q     <= '0;
            rxv_q     <= 1'b0;
            rxd_q     <= '0;
        end else begin
            cfg_q     <= cfg_d;
            group_q   <= group_d;
            lanb_q    <= lanb_d;
            suffix_q  <= suffix_d;
            lanid_q   <= lanid_d;
            seq_q     <= seq_d;
            cnt_dup_q <= cnt_dup_d;
            cnt_str_q <= cnt_str_d;
            cnt_trl_q <= cnt_trl_d;
            rdata_q   <= rdata_d;
            txv_q     <= txv_d;
            txd_q     <= txd_d;
            rxv_q     <= rxv_d;
            rxd_q     <= rxd_d;
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign tx_dec_valid_o = txv_q;
    assign tx_dec_o       = txd_q;
    assign rx_dec_valid_o = rxv_q;
    assign rx_dec_o       = rxd_q;
endmodule

// *** tb/prp_lan_model.sv ***
/* lan port pair model: takes each tx decision that appends a trailer and checks trailer
   contents; assumes register defaults for suffix and lan b select */
`timescale 1ns/1ns
module prp_lan_model
    import prp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        dec_valid_i,
    input  wire prp_tx_dec_t dec_i,
    output logic      [31:0] frames_o,
    output logic      [31:0] errs_o
);
    logic [15:0] seq_q;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            seq_q    <= 16'h0;
            frames_o <= 32'h0;
            errs_o   <= 32'h0;
        end else if (dec_valid_i && dec_i.append_mask != 4'h0) begin
            frames_o <= frames_o + 32'h1;
            seq_q    <= seq_q + 16'h1;
            if (dec_i.seq_num !== seq_q || dec_i.suffix !== PRP_RST_SUFFIX ||
                dec_i.lan_b_sel !== PRP_RST_LANB) begin
                errs_o <= errs_o + 32'h1;
            end
        end
    end
endmodule

// *** tb/prp_trailer_dup_control_sva.sv ***
/* checker on decision timing and trailer masking;
   bound to the block's top ports, one clock domain */
`timescale 1ns/1ns
module prp_sva_chk
    import prp_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic        tx_valid_i,
    input wire prp_tx_req_t tx_req_i,
    input wire logic        tx_dec_valid_o,
    input wire prp_tx_dec_t tx_dec_o,
    input wire logic        rx_valid_i,
    input wire prp_rx_req_t rx_req_i,
    input wire prp_rx_dec_t rx_dec_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence tx_bpdu_s;
        tx_valid_i && tx_req_i.is_bpdu;
    endsequence
    sequence rx_exempt_s;
        rx_valid_i && (rx_req_i.is_bpdu || rx_req_i.is_ptp);
    endsequence
    tx_dec_timing_a: assert property (tx_dec_valid_o == $past(tx_valid_i))
        else $error("tx decision timing wrong");
    bpdu_no_trl_a: assert property (tx_bpdu_s |=> tx_dec_o.append_mask == 4'h0)
        else $error("trailer on bridge frame");
    dest_only_a: assert property (tx_valid_i |=>
        (tx_dec_o.append_mask & ~$past(tx_req_i.dest_mask)) == 4'h0)
        else $error("trailer on port not sent to");
    tx_dec_hold_a: assert property (!tx_valid_i |=> $stable(tx_dec_o))
        else $error("tx decision changed unasked");
    exempt_keep_a: assert property (rx_exempt_s |=> !rx_dec_o.strip)
        else $error("exempt frame stripped");
    exempt_nodup_a: assert property (rx_exempt_s |=>
        !rx_dec_o.dup_check ##0 !rx_dec_o.discard)
        else $error("exempt frame dup checked");
    no_trl_keep_a: assert property (rx_valid_i && !rx_req_i.has_trailer |=> !rx_dec_o.strip)
        else $error("strip without trailer");
    unique_pass_a: assert property (rx_valid_i && !rx_req_i.is_dup |=> !rx_dec_o.discard)
        else $error("unique frame discarded");
endmodule
bind prp_trailer_dup_control prp_sva_chk i_prp_sva_chk (
    .clock_i(clock_i), .srst_i(srst_i), .tx_valid_i(tx_valid_i), .tx_req_i(tx_req_i),
    .tx_dec_valid_o(tx_dec_valid_o), .tx_dec_o(tx_dec_o), .rx_valid_i(rx_valid_i),
    .rx_req_i(rx_req_i), .rx_dec_o(rx_dec_o));

// *** tb/prp_trailer_dup_control_test.sv ***
/* self-checking bench: register port, tx and rx descriptors;
   assumes one 25 MHz clock and register defaults for group and ids */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
module prp_trailer_dup_control_test;
    import prp_pkg::*;
    logic        clock_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_d = 0;
    logic        tx_valid_i = 0, rx_valid_i = 0, tx_dec_valid_o, rx_dec_valid_o;
    logic [7:0]  reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, ew, frames, errs, cnt[3], rq[$];
    logic [3:0]  tw, tq[$], dl[5] = '{4'h3, 4'h7, 4'h1, 4'hE, 4'h3};
    prp_tx_req_t tx_req_i = '0;
    prp_rx_req_t rx_req_i = '0;
    prp_tx_dec_t tx_dec_o;
    prp_rx_dec_t rx_dec_o, xw, xq[$];
    int          err_count = 0, check_count = 0;
    prp_trailer_dup_control i_prp_trailer_dup_control (.clock_i(clock_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_valid_i(tx_valid_i),
        .tx_req_i(tx_req_i), .tx_dec_valid_o(tx_dec_valid_o), .tx_dec_o(tx_dec_o),
        .rx_valid_i(rx_valid_i), .rx_req_i(rx_req_i), .rx_dec_valid_o(rx_dec_valid_o),
        .rx_dec_o(rx_dec_o));
    prp_lan_model i_prp_lan_model (.clock_i(clock_i), .srst_i(srst_i),
        .dec_valid_i(tx_dec_valid_o), .dec_i(tx_dec_o), .frames_o(frames), .errs_o(errs));
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    task automatic finish_test;
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // read: d is the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!wr) rq.push_back(d);
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask
    task automatic tx(input logic [1:0] m, input logic [3:0] dm, input logic bp);
        logic [3:0] g, e;
        g = dm & 4'h3;
        case (m)
            2'b00: e = (g == 4'h3 && dm == g) ? g : 4'h0;
            2'b01: e = (g == 4'h3) ? g : 4'h0;
            2'b10: e = 4'h0;
            default: e = g;
        endcase
        e = bp ? 4'h0 : e;
        tq.push_back(e);
        if (e != 4'h0) cnt[2]++;
        @(posedge clock_i);
        tx_valid_i <= 1'b1;
        tx_req_i <= '{dm, bp, 11'($urandom_range(64, 1518))};
        @(posedge clock_i);
        tx_valid_i <= 1'b0;
    endtask
    // cf holds strip, accept and enable as in the config word
    task automatic rx(input logic [2:0] cf);
        prp_rx_req_t r;
        prp_rx_dec_t e;
        logic        ing, ex;
        r = 16'($urandom);
        r.rx_port = 4'h1 << $urandom_range(0, 3);
        if (r.lan_id[1]) r.lan_id = r.lan_id[0] ? PRP_RST_LANB_ID : PRP_RST_LANA_ID;
        ing = |(r.rx_port & PRP_RST_GROUP);
        ex = r.is_bpdu | r.is_ptp;
        e.dup_check = cf[0] & ing & !cf[1] & !ex;
        e.discard = e.dup_check & r.is_dup;
        e.strip = cf[0] & cf[2] & ing & !ex & r.has_trailer & r.src_port_mask[1]
            & r.src_port_mask[0] & (r.lan_id == (r.rx_port[1] ? 4'hB : 4'hA));
        xq.push_back(e);
        cnt[0] += 32'(e.discard);
        cnt[1] += 32'(e.strip);
        @(posedge clock_i);
        rx_valid_i <= 1'b1;
        rx_req_i <= r;
        @(posedge clock_i);
        rx_valid_i <= 1'b0;
    endtask
    always @(posedge clock_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) begin
            ew = rq.pop_front();
            `CHK(reg_rdata_o, ew)
        end
        if (tx_dec_valid_o) begin
            tw = tq.pop_front();
            `CHK(tx_dec_o.append_mask, tw)
        end
        if (rx_dec_valid_o) begin
            xw = xq.pop_front();
            `CHK(rx_dec_o, xw)
        end
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(13611));
        cnt = '{default: 32'h0};
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        bus(0, PRP_OFS_CONFIG, PRP_RST_CONFIG);
        bus(0, PRP_OFS_GROUP, 32'h0002_0003);
        bus(0, PRP_OFS_LANID, 32'h0000_00BA);
        bus(1, 8'h20, 32'hFFFF_FFFF);
        bus(0, 8'h20, 32'h0);
        bus(1, PRP_OFS_CONFIG, 32'hFFFF_FFFF);
        bus(0, PRP_OFS_CONFIG, 32'h0000_001F);
        for (int m = 0; m < 4; m++) begin
            bus(1, PRP_OFS_CONFIG, {27'h0, 2'(m), 3'b001});
            for (int d = 0; d < 5; d++) tx(2'(m), dl[d], d == 4);
        end
        for (int c = 0; c < 4; c++) begin
            bus(1, PRP_OFS_CONFIG, {29'h0, 2'(c), 1'b1});
            repeat (40) rx({2'(c), 1'b1});
        end
        repeat (2) @(posedge clock_i);
        for (int i = 0; i < 3; i++) bus(0, PRP_OFS_STAT_DUP + 8'(4 * i), cnt[i]);
        `CHK(frames, cnt[2])
        `CHK(errs, 32'h0)
        bus(1, PRP_OFS_CONFIG, 32'h0000_0000);
        repeat (8) rx(3'b110);
        for (int i = 0; i < 3; i++) bus(0, PRP_OFS_STAT_DUP + 8'(4 * i), 32'h0);
        // history memory lives outside; re-enable in a recommended mode, accept bit clear
        bus(1, PRP_OFS_CONFIG, 32'h0000_0009);
        tx(2'b01, 4'h3, 1'b0);
        bus(0, PRP_OFS_STAT_TRL, 32'h0000_0001);
        repeat (3) @(posedge clock_i);
        finish_test();
    end
endmodule
